// ---- rtl/gpb_pkg.sv ----
// constants and register map of the eight-bit general purpose port
// Operation
// - eight pins, each digital input or output
// - direction one: driver off, pin is input
// - direction zero: driver on, drives latch bit
// - data read gives pins, write updates latch
// - every data register write is read-modify-write into latch
// - direction controls drivers even in analog use
// - analog pins read zero digitally
// - per-pin weak pull-up with enable field
// - pull-up off whenever pin is output
// - global disable holds pull-ups off after reset
// - per-pin interrupt-on-change enable field
// - change interrupts disabled at reset
// - analog select forces digital reads to zero
// - analog select leaves digital output working
// - read-modify-write stores zero from analog output pins
// - analog select bits reset to analog mode
package gpb_pkg;
    localparam int GPB_W = 8;
    localparam logic [11:0] GPB_ADDR_DATA = 12'h000;
    localparam logic [11:0] GPB_ADDR_DIR = 12'h004;
    localparam logic [11:0] GPB_ADDR_LATCH = 12'h008;
    localparam logic [11:0] GPB_ADDR_PULLUP = 12'h00C;
    localparam logic [11:0] GPB_ADDR_GPD = 12'h010;
    localparam logic [11:0] GPB_ADDR_IOC = 12'h014;
    localparam logic [11:0] GPB_ADDR_ANALOG_SELECT_GENERIC = 12'h018;
    localparam logic [11:0] GPB_ADDR_STAT = 12'h01C;
    localparam logic [11:0] GPB_ADDR_MASK = 12'h020;
    localparam logic [7:0] GPB_RST_DIR = 8'hFF;
    localparam logic [7:0] GPB_RST_LATCH = 8'h00;
    localparam logic [7:0] GPB_RST_PULLUP = 8'h00;
    localparam logic GPB_RST_GPD = 1'h1;
    localparam logic [7:0] GPB_RST_IOC = 8'h00;
    localparam logic [7:0] GPB_RST_ANALOG_SELECT_GENERIC = 8'hFF;
    localparam logic [7:0] GPB_RST_MASK = 8'h00;
    localparam logic [1:0] GPB_RESP_OKAY = 2'h0;
    localparam logic [1:0] GPB_RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/gpb_port.sv ----
// eight-bit general purpose port with axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
module gpb_port
    import gpb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [GPB_W-1:0] pin_in,
    output logic [GPB_W-1:0] pin_out,
    output logic [GPB_W-1:0] pin_oe,
    output logic [GPB_W-1:0] pullup_on,
    output logic [GPB_W-1:0] analog_en,
    output logic irq
);
    typedef struct packed {
        logic awr;
        logic wr;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic got_aw;
        logic got_w;
        logic bvalid;
        logic [1:0] bresp;
        logic arr;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [GPB_W-1:0] pin_direction;
        logic [GPB_W-1:0] output_latch;
        logic [GPB_W-1:0] pullup_enable;
        logic global_pullup_disable;
        logic [GPB_W-1:0] change_irq_enable;
        logic [GPB_W-1:0] analog_select;
        logic [GPB_W-1:0] stat;
        logic [GPB_W-1:0] mask;
        logic [GPB_W-1:0] prev_read;
        logic [GPB_W-1:0] pin_out;
        logic [GPB_W-1:0] pin_oe;
        logic [GPB_W-1:0] pullup_on;
        logic irq;
    } gpb_st_t;

    gpb_st_t st_q;
    gpb_st_t st_d;
    logic [GPB_W-1:0] pin_level;
    logic [GPB_W-1:0] port_pin_data;
    logic [GPB_W-1:0] chg;

    // pins enter through the synchroniser
    gpb_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin_async(pin_in),
        .pin_level(pin_level)
    );

    // analog pins read as zero digitally
    assign port_pin_data = pin_level & ~st_q.analog_select;
    assign chg = (port_pin_data ^ st_q.prev_read) & st_q.change_irq_enable;

    function automatic logic [GPB_W-1:0] merge8(input logic [GPB_W-1:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] strb);
        merge8 = strb[0] ? wd[GPB_W-1:0] : old;
    endfunction

    always_comb begin
        logic [GPB_W-1:0] rmw;
        logic [GPB_W-1:0] clr;
        logic do_wr;
        logic [GPB_W-1:0] rd8;
        logic rd_ok;
        logic wr_ok;
        rmw = '0;
        clr = '0;
        do_wr = 1'b0;
        rd8 = '0;
        rd_ok = 1'b1;
        wr_ok = 1'b1;
        st_d = st_q;
        st_d.prev_read = port_pin_data;

        // write address and data, taken in either order
        st_d.awr = 1'b0;
        st_d.wr = 1'b0;
        if (!st_q.got_aw && !st_q.bvalid && !st_q.awr) begin
            st_d.awr = 1'b1;
        end
        if (!st_q.got_w && !st_q.bvalid && !st_q.wr) begin
            st_d.wr = 1'b1;
        end
        if (st_q.awr && s_axi_awvalid) begin
            st_d.awr = 1'b0;
            st_d.got_aw = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (st_q.wr && s_axi_wvalid) begin
            st_d.wr = 1'b0;
            st_d.got_w = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (st_q.got_aw && st_q.got_w && !st_q.bvalid) begin
            do_wr = 1'b1;
            st_d.got_aw = 1'b0;
            st_d.got_w = 1'b0;
            st_d.bvalid = 1'b1;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        // change events are sticky; hardware set wins over clear
        if (do_wr) begin
            case (st_q.awaddr)
                GPB_ADDR_DATA: begin
                    // sample pins, change selected bits, store latch
                    rmw = port_pin_data;
                    st_d.output_latch = merge8(rmw, st_q.wdata, st_q.wstrb);
                end
                GPB_ADDR_DIR: st_d.pin_direction = merge8(st_q.pin_direction, st_q.wdata,
                                                          st_q.wstrb);
                GPB_ADDR_LATCH: st_d.output_latch = merge8(st_q.output_latch, st_q.wdata,
                                                           st_q.wstrb);
                GPB_ADDR_PULLUP: st_d.pullup_enable = merge8(st_q.pullup_enable, st_q.wdata,
                                                             st_q.wstrb);
                GPB_ADDR_GPD: begin
                    if (st_q.wstrb[0]) begin
                        st_d.global_pullup_disable = st_q.wdata[0];
                    end
                end
                GPB_ADDR_IOC: st_d.change_irq_enable = merge8(st_q.change_irq_enable,
                                                              st_q.wdata, st_q.wstrb);
                GPB_ADDR_ANALOG_SELECT_GENERIC: st_d.analog_select = merge8(st_q.analog_select, st_q.wdata,
                                                            st_q.wstrb);
                GPB_ADDR_STAT: begin
                    if (st_q.wstrb[0]) begin
                        clr = st_q.wdata[GPB_W-1:0];
                    end
                end
                GPB_ADDR_MASK: st_d.mask = merge8(st_q.mask, st_q.wdata, st_q.wstrb);
                default: wr_ok = 1'b0;
            endcase
            st_d.bresp = wr_ok ? GPB_RESP_OKAY : GPB_RESP_SLVERR;
        end
        st_d.stat = (st_q.stat & ~clr) | chg;

        // read channel
        st_d.arr = !st_q.rvalid && !st_q.arr;
        if (st_q.arr && s_axi_arvalid) begin
            st_d.arr = 1'b0;
            case (s_axi_araddr)
                GPB_ADDR_DATA: rd8 = port_pin_data;
                GPB_ADDR_DIR: rd8 = st_q.pin_direction;
                GPB_ADDR_LATCH: rd8 = st_q.output_latch;
                GPB_ADDR_PULLUP: rd8 = st_q.pullup_enable;
                GPB_ADDR_GPD: rd8 = {{(GPB_W-1){1'b0}}, st_q.global_pullup_disable};
                GPB_ADDR_IOC: rd8 = st_q.change_irq_enable;
                GPB_ADDR_ANALOG_SELECT_GENERIC: rd8 = st_q.analog_select;
                GPB_ADDR_STAT: rd8 = st_q.stat;
                GPB_ADDR_MASK: rd8 = st_q.mask;
                default: rd_ok = 1'b0;
            endcase
            st_d.rvalid = 1'b1;
            st_d.rdata = {24'h000000, rd8};
            st_d.rresp = rd_ok ? GPB_RESP_OKAY : GPB_RESP_SLVERR;
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        // drivers follow direction at all times, analog or not
        st_d.pin_oe = ~st_d.pin_direction;
        st_d.pin_out = st_d.output_latch;
        // pull-up only on inputs and when not globally disabled
        st_d.pullup_on = st_d.global_pullup_disable ? '0
                       : (st_d.pullup_enable & st_d.pin_direction);
        st_d.irq = |(st_d.stat & st_d.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.pin_direction <= GPB_RST_DIR;
            st_q.output_latch <= GPB_RST_LATCH;
            st_q.pullup_enable <= GPB_RST_PULLUP;
            st_q.global_pullup_disable <= GPB_RST_GPD;
            st_q.change_irq_enable <= GPB_RST_IOC;
            st_q.analog_select <= GPB_RST_ANALOG_SELECT_GENERIC;
            st_q.mask <= GPB_RST_MASK;
            st_q.bresp <= GPB_RESP_OKAY;
            st_q.rresp <= GPB_RESP_OKAY;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = st_q.awr;
    assign s_axi_wready = st_q.wr;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arr;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign pin_out = st_q.pin_out;
    assign pin_oe = st_q.pin_oe;
    assign pullup_on = st_q.pullup_on;
    assign analog_en = st_q.analog_select; // analog functions may use pin
    assign irq = st_q.irq;
endmodule
`default_nettype wire

// ---- rtl/gpb_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module gpb_sync
    import gpb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [GPB_W-1:0] pin_async,
    output logic [GPB_W-1:0] pin_level
);
    typedef struct packed {
        logic [GPB_W-1:0] s1;
        logic [GPB_W-1:0] s2;
        logic [GPB_W-1:0] s3;
        logic [GPB_W-1:0] lvl;
    } gpb_sync_st_t;
    gpb_sync_st_t st_q;
    gpb_sync_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_async;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // change counts once stages two and three agree
        for (int i = 0; i < GPB_W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign pin_level = st_q.lvl;
endmodule
`default_nettype wire

// ---- verif/eight_bit_gpio_port_tb.sv ----
// self-checking bench for the eight-bit port
`timescale 1ns/10ps
`default_nettype none
module eight_bit_gpio_port_tb;
    import gpb_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] pin_in, pin_out, pin_oe, pullup_on, analog_en, dir, lat, ans, pu, v;
    logic [7:0] ext = 8'h00;
    logic [15:0] lfsr = 16'h6F6B;
    int num_errors = 0;
    int num_checks = 0;
    gpb_port DUT (.*);
    gpb_board u_board (.pin_out, .pin_oe, .ext_drv(ext), .pin_lvl(pin_in));
    always #25 aclk = ~aclk;
    function automatic logic [7:0] rnd();
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
        return lfsr[7:0];
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] d, l, e, a);
        return ((d & e) | (~d & l)) & ~a;
    endfunction
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1,
                      input logic [1:0] er = GPB_RESP_OKAY);
        logic pa = 1'h1;
        logic pw = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) pa = 1'h0;
            if (s_axi_wready) pw = 1'h0;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end while (pa || pw);
        // ready only once the answer stands, so a held answer is exercised
        forever begin
            @(posedge aclk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'h1;
        end
        chk("bresp", {6'h00, s_axi_bresp}, {6'h00, er});
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rc(input string n, input logic [11:0] a, input logic [7:0] e,
                      input logic [1:0] er = GPB_RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        // ready only once the answer stands, so a held answer is exercised
        forever begin
            @(posedge aclk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'h1;
        end
        chk("rresp", {6'h00, s_axi_rresp}, {6'h00, er});
        chk(n, s_axi_rdata[7:0], e);
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rst_chk;
        logic [11:0] a [8] = '{GPB_ADDR_DIR, GPB_ADDR_LATCH, GPB_ADDR_PULLUP, GPB_ADDR_GPD,
            GPB_ADDR_IOC, GPB_ADDR_ANALOG_SELECT_GENERIC, GPB_ADDR_MASK, GPB_ADDR_STAT};
        logic [7:0] e [8] = '{8'hFF, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h00, 8'h00};
        aresetn <= 1'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < 8; i++) rc("reset value", a[i], e[i]);
        chk("reset pullup", pullup_on, 8'h00);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst_chk();
        wr(12'h040, 8'hFF, 4'h1, GPB_RESP_SLVERR);
        rc("unmapped", 12'h040, 8'h00, GPB_RESP_SLVERR);
        wr(GPB_ADDR_GPD, 8'h00);
        for (int i = 0; i < 24; i++) begin
            dir = (i == 0) ? 8'h00 : rnd();
            lat = rnd();
            ans = (i == 0) ? 8'h0F : rnd();
            pu = rnd();
            ext <= rnd();
            if (i % 2 == 1) dir = dir | ans;
            wr(GPB_ADDR_ANALOG_SELECT_GENERIC, ans);
            wr(GPB_ADDR_DIR, dir);
            wr(GPB_ADDR_LATCH, lat);
            wr(GPB_ADDR_PULLUP, pu);
            repeat (6) @(posedge aclk);
            chk("oe", pin_oe, ~dir);
            chk("out", pin_out, lat);
            chk("pullup", pullup_on, pu & dir);
            chk("analog", analog_en, ans);
            rc("data", GPB_ADDR_DATA, exp_rd(dir, lat, ext, ans));
            wr(GPB_ADDR_DATA, rnd(), 4'h0);
            rc("rmw", GPB_ADDR_LATCH, exp_rd(dir, lat, ext, ans));
            v = rnd();
            wr(GPB_ADDR_DATA, v);
            @(posedge aclk);
            chk("data write", pin_out, v);
        end
        wr(GPB_ADDR_ANALOG_SELECT_GENERIC, 8'h00);
        wr(GPB_ADDR_DIR, 8'hFF);
        wr(GPB_ADDR_PULLUP, 8'hFF);
        chk("pullup all", pullup_on, 8'hFF);
        wr(GPB_ADDR_GPD, 8'h01);
        chk("pullup off", pullup_on, 8'h00);
        wr(GPB_ADDR_MASK, 8'h01);
        ext <= ext ^ 8'h01;
        repeat (8) @(posedge aclk);
        rc("no change event", GPB_ADDR_STAT, 8'h00);
        wr(GPB_ADDR_IOC, 8'h03);
        ext <= ext ^ 8'h03;
        repeat (8) @(posedge aclk);
        rc("change event", GPB_ADDR_STAT, 8'h03);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(GPB_ADDR_MASK, 8'h00);
        @(posedge aclk);
        chk("irq masked", {7'h00, irq}, 8'h00);
        wr(GPB_ADDR_MASK, 8'h01);
        wr(GPB_ADDR_STAT, 8'h01);
        @(posedge aclk);
        chk("irq cleared", {7'h00, irq}, 8'h00);
        rc("status left", GPB_ADDR_STAT, 8'h02);
        // clock enable low freezes the pin path, so the event waits for it
        ce <= 1'h0;
        ext <= ext ^ 8'h01;
        repeat (8) @(posedge aclk);
        chk("irq frozen", {7'h00, irq}, 8'h00);
        ce <= 1'h1;
        repeat (8) @(posedge aclk);
        chk("irq after freeze", {7'h00, irq}, 8'h01);
        rst_chk();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire

// ---- verif/gpb_board.sv ----
// board model: a pin shows the device drive where enabled, else the outside drive
`timescale 1ns/10ps
`default_nettype none
module gpb_board (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_drv,
    output logic [7:0] pin_lvl
);
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_drv);
endmodule
`default_nettype wire

// ---- verif/gpb_port_monitor.sv ----
// assertions on the port's bus handshakes and pin controls
`timescale 1ns/10ps
`default_nettype none
module gpb_port_monitor
    import gpb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [GPB_W-1:0] pin_oe,
    input wire logic [GPB_W-1:0] pullup_on,
    input wire logic [GPB_W-1:0] analog_en,
    input wire logic irq
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        !s_axi_awready && !s_axi_wready ##[0:1] s_axi_bvalid;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_RESP: assert property (wr_take |=> wr_answer)
        else $error("write answer missing");
    AST_RD_RESP: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_PU_OUT: assert property ((pullup_on & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_RST_PIN: assert property ($rose(aresetn) |->
        pin_oe == 8'h00 && pullup_on == 8'h00 && analog_en == 8'hFF)
        else $error("pin controls wrong after reset");
    AST_RST_IRQ: assert property ($rose(aresetn) |-> !irq ##1 !irq)
        else $error("interrupt after reset");
endmodule
bind gpb_port gpb_port_monitor u_mon (.*);
`default_nettype wire
